// *** tcr_pkg.sv ***
// Package for the capture/reload timer: register map, field positions,
// reset values and phase counts. Assumes a 25 MHz pclk drives the block.
package tcr_pkg;
   localparam logic [11:0] ADDR_CTRL = 12'h0c8;
   localparam logic [11:0] ADDR_MODE = 12'h0c9;
   localparam logic [11:0] ADDR_CAPL = 12'h0ca;
   localparam logic [11:0] ADDR_CAPH = 12'h0cb;
   localparam logic [11:0] ADDR_CNTL = 12'h0cc;
   localparam logic [11:0] ADDR_CNTH = 12'h0cd;
   localparam logic [11:0] ADDR_ISTAT = 12'h0d0;
   localparam logic [11:0] ADDR_IMASK = 12'h0d4;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] MODE_RESET = 8'h00;
   localparam int BIT_OVF = 7;
   localparam int BIT_EXF = 6;
   localparam int BIT_RCLK = 5;
   localparam int BIT_TRANSMIT_CLOCK_SELECT = 4;
   localparam int BIT_EXEN = 3;
   localparam int BIT_RUN = 2;
   localparam int BIT_CT = 1;
   localparam int BIT_CPRL = 0;
   localparam int BIT_DOWN_COUNT_ENABLE = 0;
   localparam int IRQ_OVF = 0;
   localparam int IRQ_EXF = 1;
   localparam int OSC_PER_MC = 12;
   localparam int OSC_PER_STATE = 2;
   localparam int SAMPLE_PHASE = 9;
   localparam logic [15:0] ALL_ONES = 16'hffff;
   typedef struct packed {
      logic rx_tick;
      logic tx_tick;
   } tcr_serial_t;
endpackage : tcr_pkg

// *** tcr_timer.sv ***
// Capture/reload timer with APB register slave and masked interrupt.
// Assumes count and trigger pins are asynchronous; first timer overflow
// arrives as a pclk-domain pulse.
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module tcr_timer (
   // APB
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Pins and neighbours
   input wire logic count_input_pin,
   input wire logic trigger_input_pin,
   input wire logic first_timer_ovf,
   // Results
   output tcr_pkg::tcr_serial_t serial_clk,
   output logic irq
);
   import tcr_pkg::*;
   logic [7:0] ctrl, next_ctrl, mode, next_mode;
   logic [15:0] cnt, next_cnt, cap, next_cap;
   logic [1:0] istat, next_istat, imask, next_imask;
   logic [3:0] phase, next_phase;
   logic [1:0] cs, ts;
   logic c_prev, t_prev, next_c_prev, next_t_prev;
   logic c_fall, next_c_fall, ovf_p, next_ovf_p;
   logic [31:0] next_prdata;
   logic next_irq;
   tcr_serial_t next_serial;
   logic wr, rd, mc_tick, st_tick, baud, adv, ovf, udf, trig, hit, known;
   logic [15:0] nxt;

   // Pin synchronisers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cs <= 2'b11;
         ts <= 2'b11;
      end else begin
         cs <= {cs[0], count_input_pin};
         ts <= {ts[0], trigger_input_pin};
      end
   end

   // Phase decode and mode terms
   always_comb begin
      wr = psel && penable && pwrite;
      rd = psel && !penable && !pwrite;
      next_phase = (phase == 4'(OSC_PER_MC - 1)) ? 4'h0 : phase + 4'h1;
      mc_tick = (phase == 4'(OSC_PER_MC - 1));
      st_tick = phase[0];
      baud = ctrl[BIT_RCLK] | ctrl[BIT_TRANSMIT_CLOCK_SELECT];
   end

   // Counting, capture, reload and flags
   always_comb begin
      next_ctrl = ctrl;
      next_mode = mode;
      next_cnt = cnt;
      next_cap = cap;
      next_istat = istat;
      next_imask = imask;
      next_t_prev = ts[1];
      next_c_prev = c_prev;
      next_c_fall = c_fall;
      if (phase == 4'(SAMPLE_PHASE)) begin
         next_c_prev = cs[1];
         next_c_fall = c_prev & ~cs[1];
      end
      if (ctrl[BIT_CT])
         adv = mc_tick && c_fall;
      else if (baud)
         adv = st_tick;
      else
         adv = mc_tick;
      adv = adv && ctrl[BIT_RUN];
      // down count when enabled and direction pin low
      udf = adv && !baud && !ctrl[BIT_CPRL] && mode[BIT_DOWN_COUNT_ENABLE]
            && !ts[1] && (cnt == cap);
      nxt = (udf || (mode[BIT_DOWN_COUNT_ENABLE] && !baud && !ctrl[BIT_CPRL] && !ts[1]))
            ? cnt - 16'h0001 : cnt + 16'h0001;
      ovf = adv && !udf && (cnt == ALL_ONES) && !(mode[BIT_DOWN_COUNT_ENABLE] && !baud
            && !ctrl[BIT_CPRL] && !ts[1]);
      // trigger edge, disabled by enable bit; DOWN_COUNT_ENABLE uses pin as direction
      trig = t_prev && !ts[1] && ctrl[BIT_EXEN]
             && !(mode[BIT_DOWN_COUNT_ENABLE] && !ctrl[BIT_CPRL] && !baud);
      hit = adv;
      if (hit)
         next_cnt = nxt;
      // reload on overflow in baud mode, or whenever capture mode is off
      if (ovf && (baud || !ctrl[BIT_CPRL]))
         next_cnt = cap;
      if (udf)
         next_cnt = ALL_ONES;
      if (trig && !baud && ctrl[BIT_CPRL])
         next_cap = cnt;
      if (trig && !baud && !ctrl[BIT_CPRL])
         next_cnt = cap;
      // Register writes
      if (wr) begin
         unique case (paddr)
            ADDR_CTRL: next_ctrl = pwdata[7:0];
            ADDR_MODE: next_mode = {6'h00, pwdata[1:0]};
            ADDR_CAPL: next_cap[7:0] = pwdata[7:0];
            ADDR_CAPH: next_cap[15:8] = pwdata[7:0];
            ADDR_CNTL: next_cnt[7:0] = pwdata[7:0];
            ADDR_CNTH: next_cnt[15:8] = pwdata[7:0];
            ADDR_ISTAT: next_istat = istat & ~pwdata[1:0];
            ADDR_IMASK: next_imask = pwdata[1:0];
            default: ;
         endcase
      end
      // overflow flag, not in baud mode; set wins over clear
      if ((ovf || udf) && !baud) begin
         next_ctrl[BIT_OVF] = 1'b1;
         next_istat[IRQ_OVF] = 1'b1;
      end
      // external flag; toggles as 17th bit in up/down mode
      if (trig || (trig_edge_baud(t_prev, ts[1], ctrl[BIT_EXEN], baud)))
         next_ctrl[BIT_EXF] = 1'b1;
      if ((ovf || udf) && !baud && mode[BIT_DOWN_COUNT_ENABLE] && !ctrl[BIT_CPRL])
         next_ctrl[BIT_EXF] = ~ctrl[BIT_EXF];
      // external flag interrupts unless DOWN_COUNT_ENABLE is set
      if (next_ctrl[BIT_EXF] && !ctrl[BIT_EXF] && !mode[BIT_DOWN_COUNT_ENABLE])
         next_istat[IRQ_EXF] = 1'b1;
      next_ovf_p = ovf;
      next_serial.rx_tick = ctrl[BIT_RCLK] ? ovf : first_timer_ovf;
      next_serial.tx_tick = ctrl[BIT_TRANSMIT_CLOCK_SELECT] ? ovf : first_timer_ovf;
      next_irq = |(next_istat & next_imask);
   end

   // Trigger edge in baud mode sets flag only
   function automatic logic trig_edge_baud(input logic p, input logic n,
                                           input logic en, input logic b);
      trig_edge_baud = p && !n && en && b;
   endfunction : trig_edge_baud

   // Read data mux
   always_comb begin
      known = 1'b1;
      next_prdata = 32'h0000_0000;
      unique case (paddr)
         ADDR_CTRL: next_prdata = {24'h00_0000, ctrl};
         ADDR_MODE: next_prdata = {24'h00_0000, mode};
         ADDR_CAPL: next_prdata = {24'h00_0000, cap[7:0]};
         ADDR_CAPH: next_prdata = {24'h00_0000, cap[15:8]};
         ADDR_CNTL: next_prdata = {24'h00_0000, cnt[7:0]};
         ADDR_CNTH: next_prdata = {24'h00_0000, cnt[15:8]};
         ADDR_ISTAT: next_prdata = {30'h0000_0000, istat};
         ADDR_IMASK: next_prdata = {30'h0000_0000, imask};
         default: known = 1'b0;
      endcase
   end

   // State registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= CTRL_RESET;
         mode <= MODE_RESET;
         cnt <= 16'h0000;
         cap <= 16'h0000;
         istat <= 2'b00;
         imask <= 2'b00;
         phase <= 4'h0;
         c_prev <= 1'b1;
         t_prev <= 1'b1;
         c_fall <= 1'b0;
         ovf_p <= 1'b0;
         serial_clk <= '0;
         irq <= 1'b0;
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         ctrl <= next_ctrl;
         mode <= next_mode;
         cnt <= next_cnt;
         cap <= next_cap;
         istat <= next_istat;
         imask <= next_imask;
         phase <= next_phase;
         c_prev <= next_c_prev;
         t_prev <= next_t_prev;
         c_fall <= next_c_fall;
         ovf_p <= next_ovf_p;
         serial_clk <= next_serial;
         irq <= next_irq;
         if (rd)
            prdata <= next_prdata;
         pready <= psel && !penable;
         pslverr <= psel && !penable && !known;
      end
   end

   AST_RUN_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
      (!ctrl[BIT_RUN] && !wr && !trig) |=> $stable(cnt))
      else $error("count moved while stopped");
   // no overflow flag in baud mode
   AST_NO_OVF_BAUD: assert property (@(posedge pclk) disable iff (!presetn)
      (baud && !ctrl[BIT_OVF] && !wr) |=> !ctrl[BIT_OVF])
      else $error("overflow flag set in baud mode");
   AST_OVF_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
      ovf_p |=> !ovf_p)
      else $error("overflow pulse too long");
   AST_RELOAD: assert property (@(posedge pclk) disable iff (!presetn)
      (ovf && !ctrl[BIT_CPRL] && !wr && !trig) |=> cnt == $past(cap))
      else $error("no reload on overflow");
   AST_CAPTURE: assert property (@(posedge pclk) disable iff (!presetn)
      (trig && ctrl[BIT_CPRL] && !baud && !wr) |=> cap == $past(cnt))
      else $error("capture missed");
   AST_EXF_SET: assert property (@(posedge pclk) disable iff (!presetn)
      trig |=> ctrl[BIT_EXF])
      else $error("external flag not set");
   AST_MC_RATE: assert property (@(posedge pclk) disable iff (!presetn)
      mc_tick |=> !mc_tick [*8])
      else $error("machine cycle too short");
   AST_TX_ROUTE: assert property (@(posedge pclk) disable iff (!presetn)
      (ctrl[BIT_TRANSMIT_CLOCK_SELECT] && ovf) |=> serial_clk.tx_tick)
      else $error("transmit tick missing");
   // transmit falls back to neighbour overflow
   AST_TX_NEIGHBOUR: assert property (@(posedge pclk) disable iff (!presetn)
      (!ctrl[BIT_TRANSMIT_CLOCK_SELECT] && first_timer_ovf) |=> serial_clk.tx_tick)
      else $error("neighbour transmit tick missing");
   AST_RX_ROUTE: assert property (@(posedge pclk) disable iff (!presetn)
      (ctrl[BIT_RCLK] && ovf) |=> serial_clk.rx_tick)
      else $error("receive tick missing");
   // receive falls back to neighbour overflow
   AST_RX_NEIGHBOUR: assert property (@(posedge pclk) disable iff (!presetn)
      (!ctrl[BIT_RCLK] && first_timer_ovf) |=> serial_clk.rx_tick)
      else $error("neighbour receive tick missing");
   // overflow sets flag outside baud mode
   AST_OVF_SETS_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
      (ovf && !baud) |=> ctrl[BIT_OVF])
      else $error("overflow flag not set");
   AST_OVF_STATUS: assert property (@(posedge pclk) disable iff (!presetn)
      (ovf && !baud) |=> istat[IRQ_OVF])
      else $error("overflow status not set");
   AST_BAUD_RELOAD: assert property (@(posedge pclk) disable iff (!presetn)
      (ovf && baud && !wr) |=> cnt == $past(cap))
      else $error("no reload in baud mode");
   AST_TRIG_OFF: assert property (@(posedge pclk) disable iff (!presetn)
      !ctrl[BIT_EXEN] |-> !trig)
      else $error("trigger acted while disabled");
   // no capture while clocking the serial port
   AST_BAUD_NO_CAP: assert property (@(posedge pclk) disable iff (!presetn)
      (baud && !wr) |=> $stable(cap))
      else $error("capture register moved in baud mode");
   // no external interrupt while DOWN_COUNT_ENABLE is set
   AST_DOWN_COUNT_ENABLE_NO_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
      (mode[BIT_DOWN_COUNT_ENABLE] && !istat[IRQ_EXF] && !wr) |=> !istat[IRQ_EXF])
      else $error("external status set in up/down mode");
   // external flag toggles on up/down overflow
   AST_DOWN_COUNT_ENABLE_TOGGLE: assert property (@(posedge pclk) disable iff (!presetn)
      (ovf && mode[BIT_DOWN_COUNT_ENABLE] && !ctrl[BIT_CPRL] && !baud && !wr)
      |=> ctrl[BIT_EXF] != $past(ctrl[BIT_EXF]))
      else $error("external flag did not toggle");
   // counter mode moves only on pin edges
   AST_PIN_ONLY: assert property (@(posedge pclk) disable iff (!presetn)
      (ctrl[BIT_CT] && !c_fall && !wr && !trig) |=> $stable(cnt))
      else $error("count moved without pin edge");
   // timer moves only on machine cycle
   AST_TIMER_STEP: assert property (@(posedge pclk) disable iff (!presetn)
      (!ctrl[BIT_CT] && !baud && !mc_tick && !wr && !trig)
      |=> $stable(cnt))
      else $error("count moved between machine cycles");
   // baud timer moves only on state time
   AST_STATE_STEP: assert property (@(posedge pclk) disable iff (!presetn)
      (baud && !ctrl[BIT_CT] && !st_tick && !wr) |=> $stable(cnt))
      else $error("count moved between state times");
   AST_TRIG_RELOAD: assert property (@(posedge pclk) disable iff (!presetn)
      (trig && !ctrl[BIT_CPRL] && !baud && !wr) |=> cnt == $past(cap))
      else $error("no reload on trigger edge");
   AST_IRQ_LEVEL: assert property (@(posedge pclk) disable iff (!presetn)
      irq == |(istat & imask))
      else $error("interrupt level wrong");
endmodule : tcr_timer
`default_nettype wire

// *** tcr_pin_model.sv ***
// Pin model: drives the count and trigger pins of the capture/reload timer.
// Assumes one-cycle request pulses; both pins idle high, as with pull-ups.
`timescale 1ns/1ps
`default_nettype none
module tcr_pin_model (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Pulse requests
   input wire logic cnt_go,
   input wire logic trig_go,
   // Pins
   output logic count_input_pin,
   output logic trigger_input_pin
);
   int cnt_left;
   int trig_left;
   // each level held over a machine cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_left <= 0;
         trig_left <= 0;
      end else begin
         cnt_left <= cnt_go ? 26 : (cnt_left > 0 ? cnt_left - 1 : 0);
         trig_left <= trig_go ? 26 : (trig_left > 0 ? trig_left - 1 : 0);
      end
   end
   // Low for thirteen cycles, then high again
   assign count_input_pin = !(cnt_left > 13);
   assign trigger_input_pin = !(trig_left > 13);
endmodule : tcr_pin_model
`default_nettype wire

// *** tb_timer2_capture_reload_counter.sv ***
// Self-checking bench for the capture/reload timer over APB.
// Assumes the pin model and a neighbour overflow pulse every 50 cycles.
`timescale 1ns/1ps
`default_nettype none
module tb_timer2_capture_reload_counter;
   import tcr_pkg::*;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, cnt_go = 1'b0, trig_go = 1'b0, first_timer_ovf = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata, q;
   logic pready, pslverr, irq, last_err, count_input_pin, trigger_input_pin;
   tcr_serial_t serial_clk;
   int num_errors = 0, tests_run = 0, rx_n = 0, tx_n = 0, ft_cnt = 0, r0, t0;

   tcr_timer dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .count_input_pin(count_input_pin), .trigger_input_pin(trigger_input_pin),
      .first_timer_ovf(first_timer_ovf), .serial_clk(serial_clk), .irq(irq));
   tcr_pin_model pins_u (.pclk(pclk), .presetn(presetn), .cnt_go(cnt_go),
      .trig_go(trig_go), .count_input_pin(count_input_pin),
      .trigger_input_pin(trigger_input_pin));

   // Clock
   initial begin
      forever #20 pclk = ~pclk;
   end
   // Tick counters and neighbour overflow pulses
   always @(posedge pclk) begin
      if (serial_clk.rx_tick === 1'b1) rx_n <= rx_n + 1;
      if (serial_clk.tx_tick === 1'b1) tx_n <= tx_n + 1;
      ft_cnt <= (ft_cnt == 49) ? 0 : ft_cnt + 1;
      first_timer_ovf <= (ft_cnt == 49);
   end

   task automatic wrap_up;
      $display("checks %0d errors %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : wrap_up

   task automatic chk(input string nm, input logic [31:0] lo,
                      input logic [31:0] hi, input logic [31:0] got);
      tests_run++;
      if ($isunknown(got) || got < lo || got > hi) begin
         num_errors++;
         $display("[ERR] %s expected %h..%h seen %h", nm, lo, hi, got);
      end
   endtask : chk

   // One APB transfer, held until pready
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         num_errors++;
         $display("[ERR] pready expected 1 seen %b", pready);
      end
      q = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rd(input string nm, input logic [11:0] a,
                     input logic [31:0] lo, input logic [31:0] hi);
      apb(1'b0, a, 32'h0000_0000);
      chk(nm, lo, hi, q);
   endtask : rd

   task automatic pin(input logic trig);
      @(posedge pclk);
      trig_go <= trig;
      cnt_go <= !trig;
      @(posedge pclk);
      trig_go <= 1'b0;
      cnt_go <= 1'b0;
      repeat (50) @(posedge pclk);
   endtask : pin

   // Watchdog
   initial begin
      repeat (8000) @(posedge pclk);
      num_errors++;
      wrap_up;
   end

   // Main sequence
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      rd("ctrl", ADDR_CTRL, 8'h00, 8'h00);
      rd("mode", ADDR_MODE, 8'h00, 8'h00);
      rd("unmapped", 12'h0ce, 8'h00, 8'h00);
      chk("slverr", 8'h01, 8'h01, {31'b0, last_err});
      apb(1'b1, ADDR_IMASK, 8'h03);
      apb(1'b1, ADDR_CNTL, 8'h55);
      repeat (60) @(posedge pclk);
      rd("stopped", ADDR_CNTL, 8'h55, 8'h55);
      apb(1'b1, ADDR_CNTL, 8'h00);
      apb(1'b1, ADDR_CTRL, 8'h05);
      repeat (120) @(posedge pclk);
      apb(1'b1, ADDR_CTRL, 8'h01);
      rd("rate", ADDR_CNTL, 8'h09, 8'h0b);
      apb(1'b1, ADDR_CNTL, 8'hfe);
      apb(1'b1, ADDR_CNTH, 8'hff);
      apb(1'b1, ADDR_CTRL, 8'h05);
      repeat (40) @(posedge pclk);
      rd("ovf flag", ADDR_CTRL, 8'h85, 8'h85);
      apb(1'b1, ADDR_CTRL, 8'h00);
      rd("istat", ADDR_ISTAT, 8'h01, 8'h01);
      chk("irq on", 8'h01, 8'h01, {31'b0, irq});
      apb(1'b1, ADDR_ISTAT, 8'h01);
      repeat (2) @(posedge pclk);
      chk("irq off", 8'h00, 8'h00, {31'b0, irq});
      apb(1'b1, ADDR_CAPL, 8'h34);
      apb(1'b1, ADDR_CAPH, 8'h12);
      apb(1'b1, ADDR_CNTL, 8'hff);
      apb(1'b1, ADDR_CNTH, 8'hff);
      apb(1'b1, ADDR_CTRL, 8'h04);
      repeat (20) @(posedge pclk);
      apb(1'b1, ADDR_CTRL, 8'h00);
      rd("reload hi", ADDR_CNTH, 8'h12, 8'h12);
      rd("reload lo", ADDR_CNTL, 8'h34, 8'h35);
      apb(1'b1, ADDR_ISTAT, 8'h03);
      apb(1'b1, ADDR_CNTL, 8'h10);
      apb(1'b1, ADDR_CNTH, 8'h00);
      apb(1'b1, ADDR_CTRL, 8'h06);
      repeat (3) pin(1'b0);
      rd("pin count", ADDR_CNTL, 8'h13, 8'h13);
      apb(1'b1, ADDR_CTRL, 8'h07);
      pin(1'b1);
      rd("no capture", ADDR_CAPL, 8'h34, 8'h34);
      rd("no ext flag", ADDR_CTRL, 8'h07, 8'h07);
      apb(1'b1, ADDR_CTRL, 8'h0f);
      pin(1'b1);
      rd("cap lo", ADDR_CAPL, 8'h13, 8'h13);
      rd("cap hi", ADDR_CAPH, 8'h00, 8'h00);
      rd("ext flag", ADDR_CTRL, 8'h4f, 8'h4f);
      rd("istat ext", ADDR_ISTAT, 8'h02, 8'h02);
      chk("irq ext", 8'h01, 8'h01, {31'b0, irq});
      apb(1'b1, ADDR_CTRL, 8'h00);
      apb(1'b1, ADDR_ISTAT, 8'h03);
      apb(1'b1, ADDR_MODE, 8'h01);
      apb(1'b1, ADDR_CNTL, 8'hff);
      apb(1'b1, ADDR_CNTH, 8'hff);
      apb(1'b1, ADDR_CTRL, 8'h04);
      repeat (20) @(posedge pclk);
      rd("updown ctrl", ADDR_CTRL, 8'hc4, 8'hc4);
      rd("updown istat", ADDR_ISTAT, 8'h01, 8'h01);
      apb(1'b1, ADDR_CTRL, 8'h00);
      apb(1'b1, ADDR_MODE, 8'h00);
      apb(1'b1, ADDR_ISTAT, 8'h03);
      apb(1'b1, ADDR_CAPL, 8'hf0);
      apb(1'b1, ADDR_CAPH, 8'hff);
      apb(1'b1, ADDR_CNTL, 8'hf0);
      apb(1'b1, ADDR_CNTH, 8'hff);
      apb(1'b1, ADDR_CTRL, 8'h24);
      r0 = rx_n;
      t0 = tx_n;
      repeat (320) @(posedge pclk);
      chk("rx ticks", 8'h09, 8'h0b, 32'(rx_n - r0));
      chk("tx ticks", 8'h06, 8'h07, 32'(tx_n - t0));
      rd("baud ctrl", ADDR_CTRL, 8'h24, 8'h24);
      wrap_up;
   end
endmodule : tb_timer2_capture_reload_counter
`default_nettype wire
